// *** inc/chb_map.svh ***
// Constant map for the card host bus decode block
`ifndef CHB_MAP_SVH
`define CHB_MAP_SVH
`define CHB_CD_LEVEL 1'b0
`define CHB_DREQ_RST 1'b0
`define CHB_DATA_RST 16'h0000
`define CHB_PIN_RD 0
`define CHB_PIN_WR 1
`define CHB_PIN_CE_LO 2
`define CHB_PIN_CE_HI 3
`define CHB_PIN_CS_CMD 4
`define CHB_PIN_CS_CTL 5
`define CHB_PIN_ACK 6
`define CHB_PIN_ADDR0 7
`define CHB_PIN_DATA 8
`define CHB_PIN_W 24
`define CHB_PIN_RST 24'h0000FF
`endif

// *** inc/chb_pkg.sv ***
// Types for the card host bus decode block
package chb_pkg;
  typedef enum logic [1:0] {MODE_MEM, MODE_IO, MODE_DISK} chb_mode_t;
  typedef enum logic [1:0] {DMA_IDLE, DMA_REQ, DMA_BURST} chb_dma_st_t;
endpackage

// *** hdl/chb_buf2.sv ***
// Two-entry valid/ready buffer
`timescale 1ns/10ps
module chb_buf2 #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = !wp_q;
    end
    if (pop) begin
      rp_d = !rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // chb_buf2

// *** hdl/chb_core.sv ***
// Host bus decode, byte steering and DMA burst engine of the card
`timescale 1ns/10ps
`include "chb_map.svh"
// Functional notes
// - Memory mode ignores the read strobe
// - I/O read strobe gates addressed data out
// - Disk mode without burst acts as I/O
// - Burst read data only while host ready
// - Host ready negated pauses burst sending
// - Burst write captures on both strobe edges
// - Strobe gaps lose or repeat no word
// - Both card detects tied low always
// - Card enables select card and width
// - High enable always routes odd byte
// - Low enable alone steers byte by address
// - I/O mode decodes enables as memory
// - Chip selects pick command or control block
// - Acknowledge forces selects off, word wide
// - Request held through the burst until it ends, then reassertable
// - Stop line ends the current burst
module chb_core
  import chb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire chb_mode_t mode,
  input wire logic udma_enable,
  input wire logic udma_read,
  input wire logic dma_want,
  input wire logic [15:0] io_rd_data,
  input wire logic rd_word_valid,
  output logic rd_word_ready,
  input wire logic [15:0] rd_word_data,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic card_enable_low_lane_n,
  input wire logic card_enable_high_lane_n,
  input wire logic command_block_select_n,
  input wire logic control_block_select_n,
  input wire logic dma_acknowledge_n,
  input wire logic address_bit_zero,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_lo,
  output logic data_oe_hi,
  output logic card_detect_first,
  output logic card_detect_second,
  output logic dma_request,
  output logic dev_strobe,
  output logic sel_cmd_block,
  output logic sel_ctl_block,
  output logic wr_word_valid,
  output logic [15:0] wr_word_data,
  output logic burst_done
);
  logic [`CHB_PIN_W-1:0] pin_raw, s1_q, s1_d, s2_q, s2_d;
  logic [1:0] prev_q, prev_d;
  logic rd_act, wr_pin_hi, ce_lo, ce_hi, cs_cmd, cs_ctl, ack, addr0;
  logic [15:0] din;
  logic strobe_edge, stop_rise, hbr, pop, mem_mode;
  logic rd_io, rd_disk, lone_hi, lone_lo, both_ce;
  chb_dma_st_t st_q, st_d;
  logic [15:0] dout_q, dout_d, wdat_q, wdat_d;
  logic oe_lo_q, oe_lo_d, oe_hi_q, oe_hi_d, req_q, req_d;
  logic dstb_q, dstb_d, wv_q, wv_d, cmd_q, cmd_d, ctl_q, ctl_d;
  logic done_q, done_d;
  logic [15:0] bq_data;
  logic bq_valid;

  // Every pin passes two flops before use
  assign pin_raw = {data_in, address_bit_zero, dma_acknowledge_n,
                    control_block_select_n, command_block_select_n,
                    card_enable_high_lane_n, card_enable_low_lane_n,
                    io_write_strobe_n, io_read_strobe_n};

  always_comb begin
    s1_d = pin_raw;
    s2_d = s1_q;
    prev_d = {s2_q[`CHB_PIN_WR], s2_q[`CHB_PIN_RD]};
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= `CHB_PIN_RST;
      s2_q <= `CHB_PIN_RST;
      prev_q <= 2'h3;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      prev_q <= prev_d;
    end
  end

  assign rd_act = !s2_q[`CHB_PIN_RD];
  assign wr_pin_hi = s2_q[`CHB_PIN_WR];
  assign ce_lo = !s2_q[`CHB_PIN_CE_LO];
  assign ce_hi = !s2_q[`CHB_PIN_CE_HI];
  assign cs_cmd = !s2_q[`CHB_PIN_CS_CMD];
  assign cs_ctl = !s2_q[`CHB_PIN_CS_CTL];
  assign ack = !s2_q[`CHB_PIN_ACK];
  assign addr0 = s2_q[`CHB_PIN_ADDR0];
  assign din = s2_q[`CHB_PIN_DATA +: 16];
  // Same pin carries host ready (read) or data strobe (write)
  assign hbr = rd_act;
  assign strobe_edge = (s2_q[`CHB_PIN_RD] != prev_q[0]);
  assign stop_rise = wr_pin_hi && !prev_q[1];
  assign mem_mode = (mode == MODE_MEM);

  assign both_ce = ce_lo && ce_hi;
  assign lone_hi = ce_hi && !ce_lo;
  assign lone_lo = ce_lo && !ce_hi;
  // memory mode unused; strobe gates data; same lanes
  assign rd_io = (mode == MODE_IO) && rd_act && (ce_lo || ce_hi);
  // disk reads like I/O; ack blocks selects
  assign rd_disk = (mode == MODE_DISK) && !udma_enable && rd_act
                   && !ack && (cs_cmd || cs_ctl);

  // Burst read words queue here so a host pause drops nothing
  chb_buf2 #(.W(16)) u_buf (
    .clk(clk),
    .resetn(resetn),
    .in_valid(rd_word_valid),
    .in_ready(rd_word_ready),
    .in_data(rd_word_data),
    .out_valid(bq_valid),
    .out_ready(pop),
    .out_data(bq_data)
  );

  // send only while host ready; pause otherwise
  assign pop = (st_q == DMA_BURST) && udma_read && hbr && bq_valid
               && !stop_rise;

  always_comb begin
    st_d = st_q;
    req_d = req_q;
    done_d = 1'b0;
    case (st_q)
      DMA_IDLE: begin
        if (dma_want && (mode == MODE_DISK)) begin
          st_d = DMA_REQ;
          req_d = 1'b1;
        end
      end
      DMA_REQ: begin
        if (ack) begin
          st_d = DMA_BURST;
        end
      end
      DMA_BURST: begin
        if (stop_rise || !ack) begin
          st_d = DMA_IDLE;
          req_d = 1'b0;
          done_d = 1'b1;
        end
      end
      default: begin
        st_d = DMA_IDLE;
        req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= DMA_IDLE;
      req_q <= `CHB_DREQ_RST;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      done_q <= done_d;
    end
  end

  always_comb begin
    dout_d = dout_q;
    oe_lo_d = 1'b0;
    oe_hi_d = 1'b0;
    dstb_d = dstb_q;
    cmd_d = 1'b0;
    ctl_d = 1'b0;
    if (pop) begin
      dout_d = bq_data;
      oe_lo_d = 1'b1;
      oe_hi_d = 1'b1;
      dstb_d = !dstb_q;
    end else if ((st_q == DMA_BURST) && udma_read) begin
      oe_lo_d = 1'b1;
      oe_hi_d = 1'b1;
    end else if (rd_disk) begin
      cmd_d = cs_cmd;
      ctl_d = cs_ctl && !cs_cmd;
      dout_d = io_rd_data;
      oe_lo_d = 1'b1;
      oe_hi_d = 1'b1;
    end else if (rd_io) begin
      if (both_ce) begin
        dout_d = io_rd_data;
        oe_lo_d = 1'b1;
        oe_hi_d = 1'b1;
      end else if (lone_hi) begin
        dout_d = {io_rd_data[15:8], 8'h00};
        oe_hi_d = 1'b1;
      end else begin
        // low lane byte steered by A0
        dout_d = {8'h00, addr0 ? io_rd_data[15:8] : io_rd_data[7:0]};
        oe_lo_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dout_q <= `CHB_DATA_RST;
      oe_lo_q <= 1'b0;
      oe_hi_q <= 1'b0;
      dstb_q <= 1'b0;
      cmd_q <= 1'b0;
      ctl_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_lo_q <= oe_lo_d;
      oe_hi_q <= oe_hi_d;
      dstb_q <= dstb_d;
      cmd_q <= cmd_d;
      ctl_q <= ctl_d;
    end
  end

  // one word per strobe edge; no edge, no word
  always_comb begin
    wv_d = 1'b0;
    wdat_d = wdat_q;
    if ((st_q == DMA_BURST) && !udma_read && strobe_edge) begin
      wv_d = 1'b1;
      wdat_d = din;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wv_q <= 1'b0;
      wdat_q <= `CHB_DATA_RST;
    end else begin
      wv_q <= wv_d;
      wdat_q <= wdat_d;
    end
  end

  assign card_detect_first = `CHB_CD_LEVEL;
  assign card_detect_second = `CHB_CD_LEVEL;
  assign data_out = dout_q;
  assign data_oe_lo = oe_lo_q;
  assign data_oe_hi = oe_hi_q;
  assign dma_request = req_q;
  assign dev_strobe = dstb_q;
  assign sel_cmd_block = cmd_q;
  assign sel_ctl_block = ctl_q;
  assign wr_word_valid = wv_q;
  assign wr_word_data = wdat_q;
  assign burst_done = done_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_req_up;
    (st_q == DMA_REQ) && !ack;
  endsequence
  sequence s_burst_stop;
    (st_q == DMA_BURST) && stop_rise;
  endsequence

  property p_mem_quiet;
    mem_mode && (st_q == DMA_IDLE) ##1 mem_mode |-> !data_oe_lo && !data_oe_hi;
  endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("drive in memory mode");
  property p_io_read;
    rd_io && (st_q == DMA_IDLE) |=> data_oe_lo || data_oe_hi;
  endproperty
  a_io_read: assert property (p_io_read) else $error("io read not driven");
  property p_disk_read;
    rd_disk && (st_q == DMA_IDLE) |=> data_oe_lo && data_oe_hi
      && data_out == $past(io_rd_data);
  endproperty
  a_disk_read: assert property (p_disk_read) else $error("disk read wrong");
  property p_send_ready;
    $changed(dev_strobe) |-> $past(hbr) && $past(st_q == DMA_BURST);
  endproperty
  a_send_ready: assert property (p_send_ready) else $error("sent without ready");
  property p_pause;
    !hbr |=> $stable(dev_strobe);
  endproperty
  a_pause: assert property (p_pause) else $error("sent during pause");
  property p_capture;
    (st_q == DMA_BURST) && !udma_read && strobe_edge |=>
      wr_word_valid && wr_word_data == $past(din);
  endproperty
  a_capture: assert property (p_capture) else $error("edge word lost");
  property p_no_dup;
    !strobe_edge |=> !wr_word_valid;
  endproperty
  a_no_dup: assert property (p_no_dup) else $error("word duplicated");
  property p_detect;
    !card_detect_first && !card_detect_second;
  endproperty
  a_detect: assert property (p_detect) else $error("detect not low");
  property p_odd_hi;
    rd_io && lone_hi && (st_q == DMA_IDLE) |=>
      data_oe_hi && !data_oe_lo && data_out[15:8] == $past(io_rd_data[15:8]);
  endproperty
  a_odd_hi: assert property (p_odd_hi) else $error("odd byte misrouted");
  property p_lone_lo;
    rd_io && lone_lo && addr0 && (st_q == DMA_IDLE) |=>
      data_oe_lo && !data_oe_hi && data_out[7:0] == $past(io_rd_data[15:8]);
  endproperty
  a_lone_lo: assert property (p_lone_lo) else $error("byte steer wrong");
  property p_cmd_sel;
    rd_disk && (st_q == DMA_IDLE) && cs_cmd |=> sel_cmd_block && !sel_ctl_block;
  endproperty
  a_cmd_sel: assert property (p_cmd_sel) else $error("block select wrong");
  property p_ack_quiet;
    ack |=> !sel_cmd_block && !sel_ctl_block;
  endproperty
  a_ack_quiet: assert property (p_ack_quiet) else $error("select during ack");
  property p_req_hold;
    s_req_up |=> dma_request;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_stop;
    s_burst_stop |=> burst_done && !dma_request ##1 (st_q != DMA_BURST);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end burst");
  property p_word;
    rd_io && both_ce && (st_q == DMA_IDLE) |=> data_oe_lo && data_oe_hi;
  endproperty
  a_word: assert property (p_word) else $error("word not full");
endmodule // chb_core

// *** tb/chb_host_model.sv ***
// Host bus controller model driving the card pin side
`timescale 1ns/10ps
module chb_host_model (
  input wire logic clk,
  output logic rd_n,
  output logic wr_n,
  output logic ce_lo_n,
  output logic ce_hi_n,
  output logic cs_cmd_n,
  output logic cs_ctl_n,
  output logic ack_n,
  output logic addr0,
  output logic [15:0] dq
);
  // role pin left grounded by host, not wired here
  initial begin
    {rd_n, wr_n, ce_lo_n, ce_hi_n, cs_cmd_n, cs_ctl_n, ack_n, addr0} = 8'hFF;
    dq = 16'h0000;
  end
  task automatic rd_on(input logic [4:0] sel);
    @(negedge clk);
    {ce_lo_n, ce_hi_n, addr0, cs_cmd_n, cs_ctl_n} = sel;
    rd_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic rd_off();
    rd_n = 1'b1;
    {ce_lo_n, ce_hi_n, cs_cmd_n, cs_ctl_n} = 4'hF;
    repeat (4) @(negedge clk);
  endtask
  task automatic dma_ack();
    @(negedge clk);
    ack_n = 1'b0;
    wr_n = 1'b0;
  endtask
  // ack level alone, for the refusal check
  task automatic set_ack(input logic on);
    ack_n = !on;
  endtask
  task automatic host_ready(input logic on);
    @(negedge clk);
    rd_n = !on;
  endtask
  // one word per edge, 400 ns period
  task automatic hs_word(input logic [15:0] w);
    dq = w;
    rd_n = !rd_n;
    repeat (4) @(negedge clk);
  endtask
  task automatic stop();
    @(negedge clk);
    wr_n = 1'b1;
    rd_n = 1'b1;
    // Released bus shows no stale word
    dq = ~dq;
    repeat (6) @(negedge clk);
    ack_n = 1'b1;
  endtask
endmodule // chb_host_model

// *** tb/card_host_bus_selects_strobes_test.sv ***
// Self-checking bench for the card host bus decode block
`timescale 1ns/10ps
module card_host_bus_selects_strobes_test
  import chb_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  chb_mode_t mode = MODE_MEM;
  logic ud_en = 1'b0, ud_rd = 1'b0, want = 1'b0, rv = 1'b0, ds_q = 1'b0;
  logic [15:0] rdat = 16'h0000, iod = 16'h5AC3, dq, dout, wdat;
  logic rd_n, wr_n, lo_n, hi_n, cmd_n, ctl_n, ack_n, addr0;
  logic rrdy, oe_lo, oe_hi, det_a, det_b, dreq, dstb, s_cmd, s_ctl, wv, done;
  logic [15:0] wq[$], rq[$];
  int err_total = 0, tests_run = 0, nd = 0;
  always #25 clk = ~clk;
  chb_core u_chb_core (.clk(clk), .resetn(resetn), .mode(mode), .udma_enable(ud_en),
    .udma_read(ud_rd), .dma_want(want), .io_rd_data(iod), .rd_word_valid(rv),
    .rd_word_ready(rrdy), .rd_word_data(rdat), .io_read_strobe_n(rd_n),
    .io_write_strobe_n(wr_n), .card_enable_low_lane_n(lo_n),
    .card_enable_high_lane_n(hi_n), .command_block_select_n(cmd_n),
    .control_block_select_n(ctl_n), .dma_acknowledge_n(ack_n),
    .address_bit_zero(addr0), .data_in(dq), .data_out(dout), .data_oe_lo(oe_lo),
    .data_oe_hi(oe_hi), .card_detect_first(det_a), .card_detect_second(det_b),
    .dma_request(dreq), .dev_strobe(dstb), .sel_cmd_block(s_cmd),
    .sel_ctl_block(s_ctl), .wr_word_valid(wv), .wr_word_data(wdat), .burst_done(done));
  chb_host_model u_chb_host_model (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .ce_lo_n(lo_n),
    .ce_hi_n(hi_n), .cs_cmd_n(cmd_n), .cs_ctl_n(ctl_n), .ack_n(ack_n), .addr0(addr0),
    .dq(dq));
  always @(posedge clk) begin
    if (wv === 1'b1) wq.push_back(wdat);
    if (dstb !== ds_q) rq.push_back(dout);
    if (done === 1'b1) nd++;
    ds_q <= dstb;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic t_mem();
    mode = MODE_MEM;
    u_chb_host_model.rd_on(5'b00011);
    chk("det", 16'h0, {det_a, det_b});
    chk("mem oe", 16'h0, {oe_hi, oe_lo});
    u_chb_host_model.rd_off();
  endtask
  task automatic t_io();
    logic [4:0] sel[4] = '{5'b00011, 5'b10011, 5'b01011, 5'b01111};
    logic [1:0] oe[4] = '{2'b11, 2'b10, 2'b01, 2'b01};
    logic [15:0] ex[4] = '{16'h5AC3, 16'h5A00, 16'h00C3, 16'h005A};
    logic [15:0] mk[4] = '{16'hFFFF, 16'hFF00, 16'h00FF, 16'h00FF};
    mode = MODE_IO;
    for (int i = 0; i < 4; i++) begin
      u_chb_host_model.rd_on(sel[i]);
      chk("io oe", 16'(oe[i]), {oe_hi, oe_lo});
      chk("io data", ex[i], dout & mk[i]);
      u_chb_host_model.rd_off();
    end
  endtask
  task automatic t_disk();
    mode = MODE_DISK;
    // Fresh word so the data path is not a constant
    iod = 16'h3C96;
    u_chb_host_model.rd_on(5'b11001);
    chk("cmd sel", 16'h2, {s_cmd, s_ctl});
    chk("disk word", 16'h3C96, dout);
    u_chb_host_model.rd_off();
    u_chb_host_model.rd_on(5'b11010);
    chk("ctl sel", 16'h1, {s_cmd, s_ctl});
    u_chb_host_model.rd_off();
    u_chb_host_model.set_ack(1'b1);
    u_chb_host_model.rd_on(5'b11001);
    chk("ack sel", 16'h0, {s_cmd, s_ctl});
    u_chb_host_model.rd_off();
    u_chb_host_model.set_ack(1'b0);
    // Let the released ack clear the sync flops before a request
    repeat (4) @(negedge clk);
  endtask
  task automatic req_up(input logic rd);
    ud_en = 1'b1;
    ud_rd = rd;
    want = 1'b1;
    for (int i = 0; i < 10 && dreq !== 1'b1; i++) @(negedge clk);
    want = 1'b0;
    repeat (5) @(negedge clk);
    chk("req held", 16'h1, 16'(dreq));
    u_chb_host_model.dma_ack();
    repeat (4) @(negedge clk);
  endtask
  task automatic ended(input int n0);
    u_chb_host_model.stop();
    repeat (2) @(negedge clk);
    chk("done", 16'(n0 + 1), 16'(nd));
    chk("req drop", 16'h0, 16'(dreq));
  endtask
  task automatic t_wr();
    int n0;
    req_up(1'b0);
    n0 = nd;
    wq.delete();
    for (int i = 0; i < 6; i++) begin
      // Gap after four edges
      if (i == 4) repeat (12) @(negedge clk);
      u_chb_host_model.hs_word(16'hC000 + 16'(i));
    end
    chk("wr count", 16'h6, 16'(wq.size()));
    for (int i = 0; i < wq.size(); i++) chk("wr word", 16'hC000 + 16'(i), wq[i]);
    ended(n0);
  endtask
  task automatic feed();
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      rv = 1'b1;
      rdat = 16'hA000 + 16'(i);
      while (rrdy !== 1'b1) @(negedge clk);
    end
    @(negedge clk);
    rv = 1'b0;
  endtask
  task automatic t_rd();
    int n0;
    u_chb_host_model.host_ready(1'b0);
    req_up(1'b1);
    n0 = nd;
    rq.delete();
    fork
      feed();
    join_none
    repeat (12) @(negedge clk);
    chk("paused", 16'h0, 16'(rq.size()));
    chk("buf full", 16'h0, 16'(rrdy));
    u_chb_host_model.host_ready(1'b1);
    repeat (20) @(negedge clk);
    chk("rd count", 16'h6, 16'(rq.size()));
    for (int i = 0; i < rq.size(); i++) chk("rd word", 16'hA000 + 16'(i), rq[i]);
    chk("rd oe", 16'h3, {oe_hi, oe_lo});
    ended(n0);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_mem();
    t_io();
    t_disk();
    t_wr();
    t_rd();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule // card_host_bus_selects_strobes_test
